// ===== rtl/mca_master_clock_adapter.sv
/*
  Master clock adapter: derives the recovery reference from the high reference input
  and the 1.544 MHz and 2.048 MHz master clocks from that input or the master clock
  input, under control of the global configuration register.
  Assumes both clock inputs are asynchronous pins whose edges clk can resolve;
  inputs faster than that are a behavioural model only.
*/
// Strobed register access and the address map were chosen for this implementation.
// Notes on behaviour
// R1: derive 38.88 MHz reference from high input; 10 and 19.44 MHz inputs pass through at their own rate
// R2: derive both master clocks from high input
// R3: frequency select field tells high input rate
// R4: disable bit stops the recovery reference
// R5: no high input: software enables master input
// R6: master input enabled: both clocks from it
// R7: rate select bit gives master input rate
// R8: enable clear: use high input, ignore master
// R9: source switch makes no runt pulses
`default_nettype none
module mca_master_clock_adapter
  import mca_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic highRefIn,
  input wire logic masterClkIn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [DATA_W-1:0] regRdData_q,
  output logic recoveryRefClk_q,
  output logic rate1544MasterClock_q,
  output logic rate2048MasterClock_q
);
  mca_cfg_s cfg_q;
  logic [2:0] highSync_q;
  logic [2:0] masterSync_q;
  logic highEdge;
  logic masterEdge;
  logic srcEdge;
  logic switchPending;
  logic useMaster_q;
  logic refOn_q;
  logic highSeen_q;
  logic masterSeen_q;
  logic [ACC_W-1:0] highRefStep;
  logic [ACC_W-1:0] step1544;
  logic [ACC_W-1:0] step2048;
  logic [ACC_W-1:0] refAcc_q;
  logic [ACC_W-1:0] acc1544_q;
  logic [ACC_W-1:0] acc2048_q;
  logic [ACC_W-1:0] refAcc_d;
  logic [ACC_W-1:0] acc1544_d;
  logic [ACC_W-1:0] acc2048_d;

  // pins pass three flops; only stage two and three feed the edge detectors
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      highSync_q <= 3'h0;
      masterSync_q <= 3'h0;
    end else begin
      highSync_q <= {highSync_q[1:0], highRefIn};
      masterSync_q <= {masterSync_q[1:0], masterClkIn};
    end
  end

  // both transitions step the accumulators, so a 1:1 ratio can pass through
  assign highEdge = highSync_q[1] ^ highSync_q[2];
  assign masterEdge = masterSync_q[1] ^ masterSync_q[2];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= CFG_RESET;
    end else if (regWrStb && regAddr == GLOBAL_CONFIG_ONE_OFS) begin
      cfg_q <= mca_cfg_s'(regWrData[$bits(mca_cfg_s)-1:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData_q <= '0;
    end else if (regRdStb) begin
      if (regAddr == GLOBAL_CONFIG_ONE_OFS) begin
        regRdData_q <= {{(DATA_W-$bits(mca_cfg_s)){1'b0}}, cfg_q};
      end else if (regAddr == ADAPTER_STATUS_OFS) begin
        regRdData_q <= {28'h0, masterSeen_q, highSeen_q, refOn_q, useMaster_q};
      end else begin
        regRdData_q <= '0;
      end
    end else begin
      regRdData_q <= '0;
    end
  end

  // activity flags, for software to check a source before selecting it [R5]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      highSeen_q <= 1'b0;
      masterSeen_q <= 1'b0;
    end else begin
      highSeen_q <= highSeen_q | highEdge;
      masterSeen_q <= masterSeen_q | masterEdge;
    end
  end

  always_comb begin
    case (cfg_q.highInputRateSelect) // [R3]
      MCA_HIGH_10M: highRefStep = mcaStep(KHZ_38M88, KHZ_10M);
      MCA_HIGH_19M44: highRefStep = mcaStep(KHZ_38M88, KHZ_19M44);
      MCA_HIGH_38M88: highRefStep = mcaStep(KHZ_38M88, KHZ_38M88);
      default: highRefStep = mcaStep(KHZ_38M88, KHZ_77M76);
    endcase
    if (useMaster_q) begin
      step1544 = cfg_q.masterInputRateSelect ? mcaStep(KHZ_1M544, KHZ_2M048)
                                             : mcaStep(KHZ_1M544, KHZ_1M544); // [R7]
      step2048 = cfg_q.masterInputRateSelect ? mcaStep(KHZ_2M048, KHZ_2M048)
                                             : mcaStep(KHZ_2M048, KHZ_1M544); // [R7]
    end else begin
      step1544 = '0;
      step2048 = '0;
      case (cfg_q.highInputRateSelect) // [R2] [R3]
        MCA_HIGH_10M: begin
          step1544 = mcaStep(KHZ_1M544, KHZ_10M);
          step2048 = mcaStep(KHZ_2M048, KHZ_10M);
        end
        MCA_HIGH_19M44: begin
          step1544 = mcaStep(KHZ_1M544, KHZ_19M44);
          step2048 = mcaStep(KHZ_2M048, KHZ_19M44);
        end
        MCA_HIGH_38M88: begin
          step1544 = mcaStep(KHZ_1M544, KHZ_38M88);
          step2048 = mcaStep(KHZ_2M048, KHZ_38M88);
        end
        default: begin
          step1544 = mcaStep(KHZ_1M544, KHZ_77M76);
          step2048 = mcaStep(KHZ_2M048, KHZ_77M76);
        end
      endcase
    end
  end

  // master input is ignored unless selected [R6] [R8]
  assign srcEdge = useMaster_q ? masterEdge : highEdge;
  assign switchPending = useMaster_q != cfg_q.masterInputEnable;
  assign refAcc_d = refAcc_q + highRefStep;
  assign acc1544_d = acc1544_q + step1544;
  assign acc2048_d = acc2048_q + step2048;

  // source changes only while both master clocks are low; phases carry on,
  // so no half-width pulse appears at the switch [R9]; limitation: a source that
  // stops while a master clock is high blocks the switch, so enable the master
  // input before the high input goes quiet
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      useMaster_q <= 1'b0;
    end else if (!rate1544MasterClock_q && !rate2048MasterClock_q) begin
      useMaster_q <= cfg_q.masterInputEnable; // [R6] [R8] [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc1544_q <= '0;
      acc2048_q <= '0;
      rate1544MasterClock_q <= 1'b0;
      rate2048MasterClock_q <= 1'b0;
    end else if (srcEdge) begin
      // while a switch waits, a low output holds so the other can fall to meet it [R9]
      if (!(switchPending && !rate1544MasterClock_q)) begin
        acc1544_q <= acc1544_d; // [R2] [R6]
        rate1544MasterClock_q <= acc1544_d[ACC_W-1];
      end
      if (!(switchPending && !rate2048MasterClock_q)) begin
        acc2048_q <= acc2048_d; // [R2] [R6]
        rate2048MasterClock_q <= acc2048_d[ACC_W-1];
      end
    end
  end

  // gate moves only while the reference is low; a pulse that rises on the cycle the gate closes is cut short
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refOn_q <= 1'b0;
    end else if (!recoveryRefClk_q) begin
      refOn_q <= ~cfg_q.recoveryReferenceDisable; // [R4]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refAcc_q <= '0;
      recoveryRefClk_q <= 1'b0;
    end else if (highEdge) begin
      refAcc_q <= refAcc_d; // [R1]
      recoveryRefClk_q <= refOn_q & refAcc_d[ACC_W-1]; // [R1] [R4]
    end else if (!refOn_q) begin
      recoveryRefClk_q <= 1'b0; // [R4]
    end
  end

  sequence cfgWrite;
    regWrStb && regAddr == GLOBAL_CONFIG_ONE_OFS;
  endsequence

  sequence cfgRead;
    regRdStb && regAddr == GLOBAL_CONFIG_ONE_OFS;
  endsequence

  AST_REF_STAYS_OFF: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    cfg_q.recoveryReferenceDisable && !refOn_q && !recoveryRefClk_q |=> !recoveryRefClk_q [*2])
    else $error("reference clock ran while disabled");

  AST_REF_GATE_CLOSES: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    cfg_q.recoveryReferenceDisable && !recoveryRefClk_q |=> !refOn_q)
    else $error("reference gate stayed open while disabled");

  AST_REF_FROM_HIGH: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    $rose(recoveryRefClk_q) |-> $past(highEdge) && $past(refOn_q))
    else $error("reference clock rose without a high input edge");

  AST_MASTER_FROM_SRC: assert property (@(posedge clk) disable iff (sys_rst) // [R2] [R6]
    $changed(rate1544MasterClock_q) || $changed(rate2048MasterClock_q) |-> $past(srcEdge))
    else $error("master clock moved without a source edge");

  AST_IGNORE_MASTER: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
    !useMaster_q && !highEdge |=> $stable(acc1544_q) && $stable(acc2048_q))
    else $error("master clock input used while not selected");

  AST_SWITCH_CLEAN: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    $changed(useMaster_q) |-> $past(!rate1544MasterClock_q && !rate2048MasterClock_q))
    else $error("source switched while a master clock was high");

  AST_SWITCH_HOLDS_LOW: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    switchPending && !rate1544MasterClock_q |=> !rate1544MasterClock_q)
    else $error("master clock rose while a source switch was waiting");

  AST_SEL_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    cfg_q.masterInputEnable && !rate1544MasterClock_q && !rate2048MasterClock_q |=> useMaster_q)
    else $error("master input enable not taken");

  AST_RATE_STEP: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    cfg_q.highInputRateSelect == MCA_HIGH_38M88 |-> highRefStep == {1'b1, {(ACC_W-1){1'b0}}})
    else $error("wrong scaling for the high input rate");

  AST_MASTER_RATE: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    useMaster_q && cfg_q.masterInputRateSelect |-> step2048 == {1'b1, {(ACC_W-1){1'b0}}})
    else $error("wrong scaling for the master input rate");

  AST_CFG_READBACK: assert property (@(posedge clk) disable iff (sys_rst)
    cfgWrite ##1 cfgRead |=> regRdData_q[$bits(mca_cfg_s)-1:0] == $past(regWrData[$bits(mca_cfg_s)-1:0], 2))
    else $error("configuration read back differs from write");
endmodule : mca_master_clock_adapter
`default_nettype wire

// ===== rtl/mca_pkg.sv
/*
  Package for the master clock adapter: register offsets, field positions,
  reset values, rate tables and the packed configuration carrier.
  Assumes a single 40 MHz system clock and a plain word-wide register port.
*/
`default_nettype none
package mca_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int ACC_W = 32;

  localparam logic [ADDR_W-1:0] GLOBAL_CONFIG_ONE_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] ADAPTER_STATUS_OFS = 4'h4;

  localparam int RATE_SEL_LSB = 0;
  localparam int REF_DISABLE_BIT = 2;
  localparam int MASTER_EN_BIT = 3;
  localparam int MASTER_RATE_BIT = 4;

  localparam int ST_USE_MASTER_BIT = 0;
  localparam int ST_REF_ON_BIT = 1;
  localparam int ST_HIGH_SEEN_BIT = 2;
  localparam int ST_MASTER_SEEN_BIT = 3;

  typedef enum logic [1:0] {
    MCA_HIGH_10M = 2'b00,
    MCA_HIGH_19M44 = 2'b01,
    MCA_HIGH_38M88 = 2'b10,
    MCA_HIGH_77M76 = 2'b11
  } mca_high_rate_e;

  typedef struct packed {
    logic masterInputRateSelect;
    logic masterInputEnable;
    logic recoveryReferenceDisable;
    mca_high_rate_e highInputRateSelect;
  } mca_cfg_s;

  localparam mca_cfg_s CFG_RESET = '{1'b0, 1'b0, 1'b0, MCA_HIGH_10M};

  // rates in kHz
  localparam longint KHZ_10M = 10000;
  localparam longint KHZ_19M44 = 19440;
  localparam longint KHZ_38M88 = 38880;
  localparam longint KHZ_77M76 = 77760;
  localparam longint KHZ_1M544 = 1544;
  localparam longint KHZ_2M048 = 2048;

  // phase step per source transition: 2^(ACC_W-1) * fout / fin; a ratio of one
  // or more is held at a half turn, so the output follows its source: an
  // edge-stepped accumulator can divide a clock but cannot multiply it
  function automatic logic [ACC_W-1:0] mcaStep(input longint fOut, input longint fIn);
    longint q;
    q = (fOut << (ACC_W - 1)) / fIn;
    if (fOut >= fIn) begin
      q = longint'(1) << (ACC_W - 1);
    end
    return q[ACC_W-1:0];
  endfunction
endpackage : mca_pkg
`default_nettype wire

// ===== test/tb_top.sv
/*
  Self-checking bench for the master clock adapter: register port, reference
  and master clock derivation, source selection and reference disable.
  Assumes one 40 MHz clock and pin clocks slow enough for the synchronisers.
*/
`default_nettype none
module tb_top import mca_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sysRst, hi, ms, wrStb, rdStb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdat, rdat, v;
  logic refClk, rate_1544_master_clock, rate_2048_master_clock;
  logic refP = 1'b0, t1P = 1'b0, e1P = 1'b0;
  bit hiEn = 1'b1;
  int refN, t1N, e1N, errorCnt, numChecks, dr, dt, de;

  mca_master_clock_adapter u_mca_master_clock_adapter (
    .clk(clk), .sys_rst(sysRst), .highRefIn(hi), .masterClkIn(ms),
    .regAddr(addr), .regWrData(wdat), .regWrStb(wrStb), .regRdStb(rdStb),
    .regRdData_q(rdat), .recoveryRefClk_q(refClk),
    .rate1544MasterClock_q(rate_1544_master_clock), .rate2048MasterClock_q(rate_2048_master_clock)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // rising edges of each generated clock, counted on the system clock
  always @(posedge clk) begin
    if (refClk && !refP) refN++;
    if (rate_1544_master_clock && !t1P) t1N++;
    if (rate_2048_master_clock && !e1P) e1N++;
    refP <= refClk;
    t1P <= rate_1544_master_clock;
    e1P <= rate_2048_master_clock;
  end

  task automatic reportAndStop;
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // edge counts may differ by one from the phase left in the accumulator
  task automatic near(input string nm, input int e, input int g);
    numChecks++;
    if (g < e - 1 || g > e + 1) begin
      errorCnt++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdat;
  endtask

  // write, then read on the very next cycle with no idle cycle between strobes
  task automatic wrRd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 q = rdat;
  endtask

  // n rising edges on the high pin (while hiEn), n/2 on the master pin
  task automatic run(input int n);
    int r0, t0, e0;
    r0 = refN;
    t0 = t1N;
    e0 = e1N;
    for (int i = 0; i < 2 * n; i++) begin
      repeat (2) @(posedge clk);
      if (i % 2 == 0) ms <= ~ms;
      repeat (2) @(posedge clk);
      if (hiEn) hi <= ~hi;
    end
    repeat (8) @(posedge clk);
    dr = refN - r0;
    dt = t1N - t0;
    de = e1N - e0;
  endtask

  task automatic tReset;
    rd(GLOBAL_CONFIG_ONE_OFS, v);
    chk("cfgReset", 32'h0, v);
    rd(ADAPTER_STATUS_OFS, v);
    chk("statusReset", 32'h2, v);
    rd(4'h8, v);
    chk("unmapped", 32'h0, v);
    wrRd(GLOBAL_CONFIG_ONE_OFS, 32'hFFFFFFFF, v);
    chk("cfgFields", 32'h1F, v);
  endtask

  // master input toggles at half rate, so taking it by mistake halves counts;
  // the reference is judged only where the input is not slower than it
  task automatic tHigh;
    longint fin;
    for (int s = 0; s < 4; s++) begin
      fin = (s == 0) ? KHZ_10M : (s == 1) ? KHZ_19M44 : (s == 2) ? KHZ_38M88 : KHZ_77M76;
      wr(GLOBAL_CONFIG_ONE_OFS, DATA_W'(s));
      run(800);
      if (s >= 2) near("refEdges", int'(800 * KHZ_38M88 / fin), dr);
      near("t1FromHigh", int'(800 * KHZ_1M544 / fin), dt);
      near("e1FromHigh", int'(800 * KHZ_2M048 / fin), de);
    end
  endtask

  task automatic tDisable;
    wr(GLOBAL_CONFIG_ONE_OFS, 32'h7);
    run(40);
    run(400);
    chk("refGated", 32'h0, 32'(dr));
    near("t1WhileGated", int'(400 * KHZ_1M544 / KHZ_77M76), dt);
    rd(ADAPTER_STATUS_OFS, v);
    chk("refOnBit", 32'h0, {31'h0, v[ST_REF_ON_BIT]});
  endtask

  task automatic tMaster;
    wr(GLOBAL_CONFIG_ONE_OFS, 32'h1B);
    run(40);
    run(800);
    near("t1FromMaster", int'(400 * KHZ_1M544 / KHZ_2M048), dt);
    near("e1FromMaster", 400, de);
    near("refStillHigh", int'(800 * KHZ_38M88 / KHZ_77M76), dr);
    rd(ADAPTER_STATUS_OFS, v);
    chk("useMaster", 32'h1, {31'h0, v[ST_USE_MASTER_BIT]});
    chk("seenBits", 32'h3, {30'h0, v[ST_MASTER_SEEN_BIT], v[ST_HIGH_SEEN_BIT]});
    wr(GLOBAL_CONFIG_ONE_OFS, 32'h0B);
    run(40);
    run(800);
    near("t1From1544", 400, dt);
    wr(GLOBAL_CONFIG_ONE_OFS, 32'h13);
    run(40);
    run(800);
    near("t1Back", int'(800 * KHZ_1M544 / KHZ_77M76), dt);
    // software enables the master input, then the high input goes quiet
    wr(GLOBAL_CONFIG_ONE_OFS, 32'h1B);
    run(40);
    hiEn = 1'b0;
    run(800);
    near("e1NoHigh", 400, de);
    chk("refNoHigh", 32'h0, 32'(dr));
  endtask

  initial begin
    sysRst = 1'b1;
    hi = 1'b0;
    ms = 1'b0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    addr = '0;
    wdat = '0;
    repeat (5) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    tReset();
    tHigh();
    tDisable();
    tMaster();
    reportAndStop();
  end

  // a run that stalls past this point counts as a failure
  initial begin
    #2000000;
    errorCnt++;
    reportAndStop();
  end
endmodule : tb_top
`default_nettype wire
